/* verilog/cbcc_pkg.sv */
// shared constants, register map and types of the bit/branch/call/clear core
package cbcc_pkg;

  // ****************************************************************
  // register map, byte addresses on the 32-bit bus
  // ****************************************************************
  localparam logic [15:0] REG_CTRL   = 16'h0000; // run, extended set, halted
  localparam logic [15:0] REG_PC     = 16'h0004; // program counter
  localparam logic [15:0] REG_STATUS = 16'h0008; // arithmetic flags
  localparam logic [15:0] REG_CORE   = 16'h000c; // working reg, bank select
  localparam logic [15:0] REG_SHADOW = 16'h0010; // shadow copies, read only
  localparam logic [15:0] REG_TOS    = 16'h0014; // return stack top, read only
  localparam logic [15:0] REG_WDT    = 16'h0018; // watchdog state, read only
  localparam logic [15:0] REG_FSR2   = 16'h001c; // indexed offset base pointer
  localparam logic [3:0]  PMEM_SEL   = 4'h1;     // haddr[15:12] of program window
  localparam logic [1:0]  DMEM_SEL   = 2'h1;     // haddr[15:14] of data window

  // ****************************************************************
  // instruction encodings
  // ****************************************************************
  localparam logic [3:0]  OPC_BTG    = 4'h7;     // bit toggle, top nibble
  localparam logic [7:0]  OPC_BZ     = 8'he0;    // branch on zero, top byte
  localparam logic [6:0]  OPC_CALL   = 7'h76;    // call first word, top 7 bits
  localparam logic [3:0]  OPC_SECOND = 4'hf;     // second word of two-word op
  localparam logic [6:0]  OPC_REGISTER_CLEAR_OP   = 7'h35;    // register clear, top 7 bits
  localparam logic [15:0] OPC_WATCHDOG_CLEAR_OP = 16'h0004; // watchdog clear
  localparam logic [15:0] OPC_NOP    = 16'h0000; // inserted in flushed cycles

  // ****************************************************************
  // addressing and reset values
  // ****************************************************************
  localparam logic [7:0]  ACCESS_SPLIT = 8'h5f;  // top of low access half
  localparam logic [3:0]  SFR_BANK     = 4'hf;   // bank of the upper access half
  localparam logic [20:0] PC_STEP      = 21'h2;  // bytes per program word
  localparam logic [20:0] PC_RESET     = 21'h0;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BIT_ONE      = 8'h01;
  localparam logic [7:0]  WDT_TOP      = 8'hff;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic n;   // negative
    logic ov;  // overflow
    logic z;   // zero
    logic dc;  // digit carry
    logic c;   // carry
  } cbcc_status_type;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cbcc_phase_type;

  typedef enum logic [2:0] {
    OP_NOP, OP_BTG, OP_BOV, OP_BZ, OP_CALL, OP_REGISTER_CLEAR_OP, OP_WATCHDOG_CLEAR_OP
  } cbcc_op_type;

endpackage

/* verilog/cbcc_core.sv */
// core executing toggle, branch, call and clear instructions, AHB-Lite access
`timescale 1ns/1ps
// Overview of operation
// - toggle inverts one bit, flags untouched
// - access flag zero access bank, one banked
// - extended set, low operands use indexed offset
// - overflow branch target is pc+2+2n
// - branch one cycle, taken adds nop cycle
// - zero branch target is pc+2+2n
// - call decoded from two words
// - call pushes address plus four
// - fast call copies w, status, bank
// - call loads pc<20:1>, two cycles
// - clear writes zero, sets zero flag
// - watchdog clear resets count and postscaler, not prescaler, sets flags
module cbcc_core #(
  parameter int          PMEM_WORDS   = 256,   // program store depth, max 1024
  parameter logic [7:0]  BOV_OPCODE   = 8'he4, // top byte of overflow branch
  parameter int          WDT_PRESCALE = 16,    // core clocks per watchdog tick
  parameter int          POST_BITS    = 4      // watchdog postscaler width
)(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  // ****************************************************************
  // storage and state
  // ****************************************************************
  localparam int PW = $clog2(PMEM_WORDS);
  localparam int PRE_W = $clog2(WDT_PRESCALE + 1);

  logic [15:0]              pmem [PMEM_WORDS];  // program words
  logic [7:0]               dmem [4096];        // banked data memory
  cbcc_pkg::cbcc_phase_type phase_r;            // current quarter phase
  logic                     run_r;              // software run enable
  logic                     ext_r;              // extended set enabled
  logic [20:0]              pc_r;               // byte program counter
  logic [15:0]              ir_r;               // instruction in execution
  logic                     flush_r;            // current cycle is a nop cycle
  logic [7:0]               data_r;             // operand read in Q2
  logic [7:0]               w_r, ws_r;          // working reg and shadow
  logic [3:0]               bsr_r, bank_select_shadow_r;      // bank select and shadow
  cbcc_pkg::cbcc_status_type st_r, sts_r;       // flags and shadow
  logic [20:0]              tos_r;              // return stack top
  logic [11:0]              fsr2_r;             // indexed base pointer
  logic [7:0]               wdt_cnt_r;          // watchdog counter
  logic [POST_BITS-1:0]     wdt_post_r;         // watchdog postscaler
  logic [PRE_W-1:0]         wdt_pre_r;          // tick divider
  logic                     to_n_r, pd_n_r;     // time-out and power-down bits

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic cbcc_pkg::cbcc_op_type decode_op(input logic [15:0] ir,
                                                      input logic [7:0]  branch_on_overflow_op);
    if (ir == cbcc_pkg::OPC_WATCHDOG_CLEAR_OP) return cbcc_pkg::OP_WATCHDOG_CLEAR_OP;
    if (ir[15:12] == cbcc_pkg::OPC_BTG) return cbcc_pkg::OP_BTG;
    if (ir[15:8] == cbcc_pkg::OPC_BZ) return cbcc_pkg::OP_BZ;
    if (ir[15:8] == branch_on_overflow_op) return cbcc_pkg::OP_BOV;
    if (ir[15:9] == cbcc_pkg::OPC_CALL) return cbcc_pkg::OP_CALL;
    if (ir[15:9] == cbcc_pkg::OPC_REGISTER_CLEAR_OP) return cbcc_pkg::OP_REGISTER_CLEAR_OP;
    // second words and everything outside this block run as nop
    return cbcc_pkg::OP_NOP;
  endfunction

  // effective data address of a register operand
  function automatic logic [11:0] eff_addr(input logic       a,
                                           input logic [7:0] f,
                                           input logic       ext,
                                           input logic [3:0] bank_select_reg,
                                           input logic [11:0] fsr2);
    if (a) return {bank_select_reg, f};
    if (ext && f <= cbcc_pkg::ACCESS_SPLIT) return fsr2 + {4'h0, f};
    if (f <= cbcc_pkg::ACCESS_SPLIT) return {4'h0, f};
    return {cbcc_pkg::SFR_BANK, f};
  endfunction

  cbcc_pkg::cbcc_op_type op;
  logic [11:0] ea;
  logic        taken;        // branch condition met
  logic [20:0] br_target;    // pc + 2n, pc already past the branch
  logic [15:0] word2;        // second word of a call
  logic [20:0] call_target;
  logic        q1, q2, q3, q4;
  logic        dm_we;        // core data write in Q4
  logic [7:0]  dm_wdata;

  assign op          = decode_op(ir_r, BOV_OPCODE);
  assign ea          = eff_addr(ir_r[8], ir_r[7:0], ext_r, bsr_r, fsr2_r);
  assign taken       = (op == cbcc_pkg::OP_BOV && st_r.ov) ||
                       (op == cbcc_pkg::OP_BZ && st_r.z);
  assign br_target   = pc_r + {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
  assign word2       = pmem[pc_r[PW:1]];
  assign call_target = {word2[11:0], ir_r[7:0], 1'b0};
  // Q1 only counts while running; later phases finish the cycle regardless
  assign q1 = phase_r == cbcc_pkg::PH_Q1 && run_r;
  assign q2 = phase_r == cbcc_pkg::PH_Q2;
  assign q3 = phase_r == cbcc_pkg::PH_Q3;
  assign q4 = phase_r == cbcc_pkg::PH_Q4;

  // data write-back of toggle and clear
  always_comb
  begin
    dm_we    = 1'b0;
    dm_wdata = data_r;
    if (q4 && op == cbcc_pkg::OP_BTG)
    begin
      dm_we    = 1'b1;
      dm_wdata = data_r ^ (cbcc_pkg::BIT_ONE << ir_r[11:9]);
    end
    else if (q4 && op == cbcc_pkg::OP_REGISTER_CLEAR_OP)
    begin
      dm_we    = 1'b1;
      dm_wdata = cbcc_pkg::BYTE_ZERO;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic        bus_we_r;    // write data phase pending
  logic [15:0] bus_addr_r;  // latched byte address
  logic        take;
  logic        wr_ctrl, wr_pc, wr_status, wr_core, wr_fsr2;

  assign take      = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;  // zero wait states, every access okay
  assign HRESP     = 1'b0;
  assign wr_ctrl   = bus_we_r && bus_addr_r == cbcc_pkg::REG_CTRL;
  assign wr_pc     = bus_we_r && bus_addr_r == cbcc_pkg::REG_PC;
  assign wr_status = bus_we_r && bus_addr_r == cbcc_pkg::REG_STATUS;
  assign wr_core   = bus_we_r && bus_addr_r == cbcc_pkg::REG_CORE;
  assign wr_fsr2   = bus_we_r && bus_addr_r == cbcc_pkg::REG_FSR2;

  // address phase capture
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      bus_we_r   <= 1'b0;
      bus_addr_r <= 16'h0000;
    end
    else
    begin
      bus_we_r <= take && HWRITE;
      if (take)
        bus_addr_r <= HADDR[15:0];
    end
  end

  // read data registered at the address phase, so it stands all data phase
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      HRDATA <= 32'h0000_0000;
    else if (take && !HWRITE)
    begin
      unique case (HADDR[15:0])
        cbcc_pkg::REG_CTRL:   HRDATA <= {29'h0, !run_r && phase_r == cbcc_pkg::PH_Q1,
                                         ext_r, run_r};
        cbcc_pkg::REG_PC:     HRDATA <= {11'h0, pc_r};
        cbcc_pkg::REG_STATUS: HRDATA <= {27'h0, st_r};
        cbcc_pkg::REG_CORE:   HRDATA <= {20'h0, bsr_r, w_r};
        cbcc_pkg::REG_SHADOW: HRDATA <= {12'h0, bank_select_shadow_r, 3'h0, sts_r, ws_r};
        cbcc_pkg::REG_TOS:    HRDATA <= {11'h0, tos_r};
        cbcc_pkg::REG_WDT:    HRDATA <= {14'h0, pd_n_r, to_n_r,
                                         8'(wdt_post_r), wdt_cnt_r};
        cbcc_pkg::REG_FSR2:   HRDATA <= {20'h0, fsr2_r};
        default:
          if (HADDR[15:12] == cbcc_pkg::PMEM_SEL)
            HRDATA <= {16'h0, pmem[HADDR[PW+1:2]]};
          else if (HADDR[15:14] == cbcc_pkg::DMEM_SEL)
            HRDATA <= {24'h0, dmem[HADDR[13:2]]};
          else
            HRDATA <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // software control bits
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      run_r  <= 1'b0;
      ext_r  <= 1'b0;
      fsr2_r <= 12'h000;
    end
    else
    begin
      if (wr_ctrl)
      begin
        run_r <= HWDATA[0];
        ext_r <= HWDATA[1];
      end
      if (wr_fsr2)
        fsr2_r <= HWDATA[11:0];
    end
  end

  // ****************************************************************
  // quarter phase sequencer
  // ****************************************************************
  // halting only takes effect at a cycle boundary
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      phase_r <= cbcc_pkg::PH_Q1;
    else
    begin
      unique case (phase_r)
        cbcc_pkg::PH_Q1: if (run_r) phase_r <= cbcc_pkg::PH_Q2;
        cbcc_pkg::PH_Q2: phase_r <= cbcc_pkg::PH_Q3;
        cbcc_pkg::PH_Q3: phase_r <= cbcc_pkg::PH_Q4;
        cbcc_pkg::PH_Q4: phase_r <= cbcc_pkg::PH_Q1;
      endcase
    end
  end

  // ****************************************************************
  // fetch and program flow
  // ****************************************************************
  // core updates of pc win over a software write in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pc_r    <= cbcc_pkg::PC_RESET;
      ir_r    <= cbcc_pkg::OPC_NOP;
      flush_r <= 1'b0;
    end
    else if (q1)
    begin
      // decode phase: a flushed cycle fetches nothing
      if (flush_r)
        ir_r <= cbcc_pkg::OPC_NOP;
      else
      begin
        ir_r <= pmem[pc_r[PW:1]];
        pc_r <= pc_r + cbcc_pkg::PC_STEP;
      end
    end
    else if (q4)
    begin
      flush_r <= 1'b0;
      if (taken)
      begin
        pc_r    <= br_target;
        flush_r <= 1'b1;
      end
      else if (op == cbcc_pkg::OP_CALL)
      begin
        pc_r    <= call_target;
        flush_r <= 1'b1;
      end
    end
    else if (wr_pc)
      pc_r <= HWDATA[20:0];
  end

  // ****************************************************************
  // data path
  // ****************************************************************
  // operand read in Q2
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      data_r <= cbcc_pkg::BYTE_ZERO;
    else if (q2)
      data_r <= dmem[ea];
  end

  // memories: core write-back has priority over bus writes to data memory
  always_ff @(posedge SYS_CLK)
  begin
    if (dm_we)
      dmem[ea] <= dm_wdata;
    else if (bus_we_r && bus_addr_r[15:14] == cbcc_pkg::DMEM_SEL)
      dmem[bus_addr_r[13:2]] <= HWDATA[7:0];
    if (bus_we_r && bus_addr_r[15:12] == cbcc_pkg::PMEM_SEL)
      pmem[bus_addr_r[PW+1:2]] <= HWDATA[15:0];
  end

  // flags: the zero set by a clear beats a software write
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      st_r <= '0;
    else
    begin
      if (wr_status)
        st_r <= cbcc_pkg::cbcc_status_type'(HWDATA[4:0]);
      if (q4 && op == cbcc_pkg::OP_REGISTER_CLEAR_OP)
        st_r.z <= 1'b1;
    end
  end

  // working and bank registers, software owned
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      w_r   <= cbcc_pkg::BYTE_ZERO;
      bsr_r <= 4'h0;
    end
    else if (wr_core)
    begin
      w_r   <= HWDATA[7:0];
      bsr_r <= HWDATA[11:8];
    end
  end

  // call push and shadow copy in Q3
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tos_r  <= cbcc_pkg::PC_RESET;
      ws_r   <= cbcc_pkg::BYTE_ZERO;
      sts_r  <= '0;
      bank_select_shadow_r <= 4'h0;
    end
    else if (q3 && op == cbcc_pkg::OP_CALL)
    begin
      tos_r <= pc_r + cbcc_pkg::PC_STEP;
      if (ir_r[8])
      begin
        ws_r   <= w_r;
        sts_r  <= st_r;
        bank_select_shadow_r <= bsr_r;
      end
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  // prescaler is left running on a clear; at most one tick of skew
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wdt_pre_r  <= '0;
      wdt_cnt_r  <= cbcc_pkg::BYTE_ZERO;
      wdt_post_r <= '0;
      to_n_r     <= 1'b1;
      pd_n_r     <= 1'b1;
    end
    else
    begin
      wdt_pre_r <= (wdt_pre_r == PRE_W'(WDT_PRESCALE - 1)) ? '0 : wdt_pre_r + 1'b1;
      if (q3 && op == cbcc_pkg::OP_WATCHDOG_CLEAR_OP)
      begin
        wdt_cnt_r  <= cbcc_pkg::BYTE_ZERO;
        wdt_post_r <= '0;
        to_n_r     <= 1'b1;
        pd_n_r     <= 1'b1;
      end
      else if (wdt_pre_r == PRE_W'(WDT_PRESCALE - 1))
      begin
        wdt_cnt_r <= wdt_cnt_r + 1'b1;
        if (wdt_cnt_r == cbcc_pkg::WDT_TOP)
        begin
          wdt_post_r <= wdt_post_r + 1'b1;
          if (&wdt_post_r)
            to_n_r <= 1'b0; // time-out seen
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  a_toggle_one_bit: assert property (q4 && op == cbcc_pkg::OP_BTG && !wr_status |->
    dm_we && $countones(dm_wdata ^ data_r) == 1 ##1 st_r == $past(st_r))
    else $error("toggle changed wrong bits or flags");
  a_bank_select: assert property (q2 && ir_r[8] |-> ea == {bsr_r, ir_r[7:0]})
    else $error("banked address wrong");
  a_indexed_mode: assert property (q2 && !ir_r[8] && ext_r &&
    ir_r[7:0] <= cbcc_pkg::ACCESS_SPLIT |-> ea == fsr2_r + {4'h0, ir_r[7:0]})
    else $error("indexed offset address wrong");
  a_ov_target: assert property (q4 && op == cbcc_pkg::OP_BOV && st_r.ov |=>
    pc_r == $past(br_target))
    else $error("overflow branch target wrong");
  a_branch_taken: assert property (q4 && taken |=> (flush_r && !dm_we) [*4])
    else $error("taken branch lacks nop cycle");
  a_branch_skip: assert property (q4 && !taken &&
    (op == cbcc_pkg::OP_BZ || op == cbcc_pkg::OP_BOV) |=> !flush_r && $stable(pc_r))
    else $error("untaken branch altered flow");
  a_bz_target: assert property (q4 && op == cbcc_pkg::OP_BZ && st_r.z |=>
    pc_r == $past(pc_r) + {{12{$past(ir_r[7])}}, $past(ir_r[7:0]), 1'b0})
    else $error("zero branch target wrong");
  a_call_target: assert property (q4 && op == cbcc_pkg::OP_CALL |=>
    pc_r[20:1] == {$past(word2[11:0]), $past(ir_r[7:0])} && flush_r)
    else $error("call target wrong");
  a_call_push: assert property (q3 && op == cbcc_pkg::OP_CALL |=>
    tos_r == $past(pc_r) + cbcc_pkg::PC_STEP)
    else $error("call pushed wrong return address");
  a_shadow_hold: assert property (q3 && op == cbcc_pkg::OP_CALL && !ir_r[8] |=>
    $stable(ws_r) && $stable(sts_r) && $stable(bank_select_shadow_r))
    else $error("shadow changed on plain call");
  a_shadow_copy: assert property (q3 && op == cbcc_pkg::OP_CALL && ir_r[8] |=>
    ws_r == $past(w_r) && sts_r == $past(st_r) && bank_select_shadow_r == $past(bsr_r))
    else $error("fast call shadow copy wrong");
  a_clear_zero: assert property (q4 && op == cbcc_pkg::OP_REGISTER_CLEAR_OP |->
    dm_we && dm_wdata == cbcc_pkg::BYTE_ZERO ##1 st_r.z)
    else $error("clear did not zero or set flag");
  a_wdt_clear: assert property (q3 && op == cbcc_pkg::OP_WATCHDOG_CLEAR_OP |=>
    wdt_cnt_r == cbcc_pkg::BYTE_ZERO && wdt_post_r == '0 && to_n_r && pd_n_r)
    else $error("watchdog clear incomplete");
  a_phase_walk: assert property (q2 |=> q3 ##1 q4 ##1 phase_r == cbcc_pkg::PH_Q1)
    else $error("quarter phase order broken");
  a_second_word_nop: assert property (!q1 && ir_r[15:12] == cbcc_pkg::OPC_SECOND |->
    op == cbcc_pkg::OP_NOP && !dm_we)
    else $error("second word executed");

endmodule // cbcc_core

/* testbench/cbcc_host_model.sv */
// bus master model standing in front of the core on the AHB-Lite side
`timescale 1ns/1ps
module cbcc_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  // ****************************************
  // idle bus at time zero
  // ****************************************
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // one transfer; entered just after a rising edge, leaves just after one
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    // address phase held until hready is seen high
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    // data phase held, read data taken at the same edge
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // cbcc_host_model

/* testbench/tb_cpu_bit_branch_call_clear_ops.sv */
// self-checking bench: loads a program, runs the core, compares with expected values
`timescale 1ns/1ps
module tb_cpu_bit_branch_call_clear_ops;
  // ****************************************
  // clock, reset and bus wiring
  // ****************************************
  logic        sys_clk = 1'b0; // 40 MHz core clock
  logic        resetn  = 1'b0; // active low reset
  logic        hsel;           // bus select from the host
  logic [31:0] haddr;          // byte address
  logic [1:0]  htrans;         // transfer type
  logic        hwrite;         // direction
  logic [31:0] hwdata;         // write data
  logic [31:0] hrdata;         // read data
  logic        hreadyout;      // slave ready, fed back as hready
  logic        hresp;          // response, checked okay after reset
  int          fail_count = 0; // mismatches
  int          n_checks   = 0; // comparisons
  int          cyc        = 0; // timeout counter
  logic [31:0] q;              // last read value
  logic [15:0] seed = 16'hf3ef; // lfsr state, starts at 62447
  logic [7:0]  d_val;          // random byte to toggle
  logic [7:0]  w_val;          // random working register
  int          cyc_run = 0;    // cycle count when the core is started
  logic        wdt_ok;         // watchdog count within ticks since start
  localparam int WDT_TICK = 16; // core clocks per watchdog tick, core default
  logic [15:0] prog [0:19];    // program image, word per entry

  always #12.5 sys_clk = ~sys_clk;

  cbcc_core #(.PMEM_WORDS(32)) i_dut (
    .SYS_CLK   (sys_clk),
    .RESETN    (resetn),
    .HSEL      (hsel),
    .HADDR     (haddr),
    .HTRANS    (htrans),
    .HWRITE    (hwrite),
    .HSIZE     (3'b010),
    .HWDATA    (hwdata),
    .HREADY    (hreadyout),
    .HRDATA    (hrdata),
    .HREADYOUT (hreadyout),
    .HRESP     (hresp)
  );

  cbcc_host_model i_host (
    .clk    (sys_clk),
    .hready (hreadyout),
    .hrdata (hrdata),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hwdata (hwdata)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    prog = '{16'h7820, 16'h6b10, 16'he001, 16'h6a30, 16'hed10, 16'hf000,
             16'h7205, 16'hec0e, 16'hf000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'he0ff,
             16'h0,
             16'h0004, 16'hf321, 16'he47f, 16'he0ff};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(32'h0);
    // a stopped core sitting at a cycle boundary reports halted
    chk("ctrl", q, 32'h4);
    chk("hresp", {31'h0, hresp}, 32'h0);
    rd(32'h18);
    chk("wdt flags", {30'h0, q[17:16]}, 32'h3);
    $display("test reset done");
    seed  = lfsr(seed);
    d_val = seed[7:0];
    seed  = lfsr(seed);
    w_val = seed[7:0];
    for (int i = 0; i < 32; i++)
      wr(32'h1000 + 4 * i, (i < 20) ? {16'h0, prog[i]} : 32'h0);
    wr(32'h4000 + 4 * 32'h020, {24'h0, d_val});
    wr(32'h4000 + 4 * 32'h310, 32'hff);
    wr(32'h4000 + 4 * 32'h030, 32'h77);
    wr(32'h0c, {20'h0, 4'h3, w_val});
    wr(32'h0, 32'h1);
    cyc_run = cyc;
    repeat (160) @(posedge sys_clk);
    wr(32'h0, 32'h0);
    repeat (8) @(posedge sys_clk);
    rd(32'h4000 + 4 * 32'h020);
    chk("toggled byte", q, {24'h0, d_val ^ 8'h10});
    rd(32'h4000 + 4 * 32'h310);
    chk("cleared banked byte", q, 32'h0);
    rd(32'h4000 + 4 * 32'h030);
    chk("skipped clear", q, 32'h77);
    rd(32'h08);
    chk("status", q, 32'h04);
    rd(32'h14);
    chk("stack top", q, 32'h0c);
    rd(32'h10);
    chk("shadows", q, {12'h0, 4'h3, 3'h0, 5'h04, w_val});
    rd(32'h04);
    chk("pc in end loop", {31'h0, q === 32'h26 || q === 32'h28}, 32'h1);
    rd(32'h18);
    chk("wdt flags after clear", {30'h0, q[17:16]}, 32'h3);
    // without the clear the count would include the whole load phase
    wdt_ok = q[7:0] <= 8'((cyc - cyc_run) / WDT_TICK + 1);
    chk("wdt count", {31'h0, wdt_ok}, 32'h1);
    chk("wdt postscaler", {24'h0, q[15:8]}, 32'h0);
    rd(32'h0);
    chk("ctrl halted", q, 32'h4);
    $display("test program done");
    // second run: indexed toggle, then a plain call that must leave shadows alone
    wr(32'h1c, 32'h200);
    wr(32'h4000 + 4 * 32'h205, {24'h0, w_val});
    wr(32'h4000 + 4 * 32'h005, 32'h5a);
    wr(32'h0c, {20'h0, 4'h5, ~w_val});
    wr(32'h04, 32'h0c);
    wr(32'h0, 32'h3);
    repeat (60) @(posedge sys_clk);
    wr(32'h0, 32'h0);
    repeat (8) @(posedge sys_clk);
    rd(32'h4000 + 4 * 32'h205);
    chk("indexed toggle", q, {24'h0, w_val ^ 8'h02});
    rd(32'h4000 + 4 * 32'h005);
    chk("access byte kept", q, 32'h5a);
    rd(32'h14);
    chk("plain call stack top", q, 32'h12);
    rd(32'h10);
    chk("shadows kept", q, {12'h0, 4'h3, 3'h0, 5'h04, w_val});
    rd(32'h04);
    chk("pc after plain call", q, 32'h1c);
    $display("test second run done");
    test_done();
  end
endmodule // tb_cpu_bit_branch_call_clear_ops
